// [bms_top.sv]
`timescale 1ns/1ps
// How it works
// [RULE_01] With repeats, reference sync runs only before the first measurement.
// [RULE_02] After sync, reference keeps advancing on every bit across cycles.
// [RULE_03] Lock is kept even when the error rate becomes worse.
// [RULE_04] Lost sync is not reacquired until a new trigger starts a sequence.
// [RULE_05] Active output high from trigger to end; triggers ignored meanwhile.
// [RULE_06] Status register shows whether a measurement is running.
// [RULE_07] Active output falls a latency after the result pulse falls.
// [RULE_08] Next trigger only after the active output has fallen.
// [RULE_09] Previous result pulse ends before the current active output falls.
// [RULE_10] Default block is 10000 bits; clean matching data gives zero errors.
// [RULE_11] Auxiliary output drives a 9-stage sequence for loopback self-test.
// [RULE_12] Absent data raises no-data and errors keep counting near half.
// [RULE_13] Returning data clears no-data and zeroes the errored-bit count.
// [RULE_14] Absent bit clock raises no-clock; clears on return; sync loss shows.
// [RULE_15] Disable then enable restarts with fresh sync and zero errors.
// [RULE_16] With gating on, bit clock edges count only at the chosen gate level.
// [RULE_17] Bit delay discards bits after trigger then needs a longer clean run.
// [RULE_18] Auto relock restarts when an intermediate error ratio exceeds limit.
// [RULE_19] Runs of 160+ selected bits are not errors but still counted.
// [RULE_20] Error ratio is errored bits over total compared bits.
module bms_top import bms_pkg::*; (
  input wire logic aclk, // System clock.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic [7:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [7:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  input wire logic bit_clock_in, // Bit clock from the unit under test.
  input wire logic bit_data_in, // Serial data from the unit under test.
  input wire logic clock_qualifier_in, // Gate for the bit clock.
  output logic measurement_active_out, // High while a measurement runs.
  output logic result_pulse_out, // Pulse when a result is ready.
  output logic aux_sequence_out // Local sequence for loopback.
);

  //////////////////////////////////////////////////////////////////////////////
  // Declarations.
  logic aw_hold, w_hold, trig_wr, wr_fire;
  logic [7:0] aw_addr;
  logic [31:0] w_data, rd_mux;
  logic [3:0] w_strb;
  logic [31:0] ctrl, block_len, cycles, delay, limit;
  logic clk_s1, clk_s2, clk_s3, dat_s1, dat_s2, gat_s1, gat_s2;
  logic clk_rise, gate_ok, bit_stb, bit_d, pred, err_bit, run_same, counting;
  logic [PN_ORDER-1:0] ref_q, aux_q;
  logic [15:0] idle_cnt, same_run, win_cnt, div_q, ratio;
  logic no_clock, no_data, last_bit, locked, sync_lost, meas_go, relock_hit;
  logic [31:0] tot_cnt, err_cnt, pend, win_err, tmr, match_run, done_cnt, sync_need;
  logic [31:0] next_err, next_pend;
  logic ign_hit, next_hit, div_done;
  logic [4:0] div_i;
  logic [32:0] div_rem, div_shift;
  bms_state_t state;

  // Word-aligned offsets that the slave answers with OKAY.
  function automatic logic reg_hit(input logic [7:0] a);
    return a == ADDR_CTRL || a == ADDR_TRIG || a == ADDR_BLOCK || a == ADDR_CYCLES ||
           a == ADDR_DELAY || a == ADDR_LIMIT || a == ADDR_STATUS || a == ADDR_TOTAL ||
           a == ADDR_ERRORS || a == ADDR_RATIO || a == ADDR_DONE;
  endfunction

  // Byte-lane merge of a write into a stored word.
  function automatic logic [31:0] wr_merge(input logic [31:0] old, input logic [31:0] d,
                                           input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Write channels. Address and data are held independently; the response
  // waits for both, and both readies stay low until the response is taken.
  assign wr_fire = aw_hold && w_hold && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= reg_hit(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Configuration registers; a trigger write is a one-cycle pulse.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= CTRL_RST;
      block_len <= BLOCK_RST; // RULE_10
      cycles <= CYCLES_RST;
      delay <= DELAY_RST;
      limit <= LIMIT_RST;
      trig_wr <= 1'b0;
    end else begin
      trig_wr <= wr_fire && aw_addr == ADDR_TRIG && w_strb[0] && w_data[0];
      if (wr_fire) begin
        if (aw_addr == ADDR_CTRL) begin
          ctrl <= wr_merge(ctrl, w_data, w_strb);
        end else if (aw_addr == ADDR_BLOCK) begin
          block_len <= wr_merge(block_len, w_data, w_strb);
        end else if (aw_addr == ADDR_CYCLES) begin
          cycles <= wr_merge(cycles, w_data, w_strb);
        end else if (aw_addr == ADDR_DELAY) begin
          delay <= wr_merge(delay, w_data, w_strb);
        end else if (aw_addr == ADDR_LIMIT) begin
          limit <= wr_merge(limit, w_data, w_strb);
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read channel, one cycle from address to data. Unmapped reads give zero.
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (s_axi_araddr == ADDR_CTRL) begin
      rd_mux = ctrl;
    end else if (s_axi_araddr == ADDR_BLOCK) begin
      rd_mux = block_len;
    end else if (s_axi_araddr == ADDR_CYCLES) begin
      rd_mux = cycles;
    end else if (s_axi_araddr == ADDR_DELAY) begin
      rd_mux = delay;
    end else if (s_axi_araddr == ADDR_LIMIT) begin
      rd_mux = limit;
    end else if (s_axi_araddr == ADDR_STATUS) begin
      rd_mux[STAT_ACTIVE] = measurement_active_out; // RULE_06
      rd_mux[STAT_LOCKED] = locked;
      rd_mux[STAT_NO_DATA] = no_data;
      rd_mux[STAT_NO_CLOCK] = no_clock;
      rd_mux[STAT_SYNC_LOST] = sync_lost;
      rd_mux[STAT_RESULT] = result_pulse_out;
    end else if (s_axi_araddr == ADDR_TOTAL) begin
      rd_mux = tot_cnt;
    end else if (s_axi_araddr == ADDR_ERRORS) begin
      rd_mux = err_cnt;
    end else if (s_axi_araddr == ADDR_RATIO) begin
      rd_mux = {16'h0000, ratio};
    end else if (s_axi_araddr == ADDR_DONE) begin
      rd_mux = done_cnt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= reg_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; bit rates must stay well under a quarter of aclk.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {clk_s1, clk_s2, clk_s3, dat_s1, dat_s2, gat_s1, gat_s2} <= 7'h00;
    end else begin
      {clk_s1, clk_s2, clk_s3} <= {bit_clock_in, clk_s1, clk_s2};
      {dat_s1, dat_s2} <= {bit_data_in, dat_s1};
      {gat_s1, gat_s2} <= {clock_qualifier_in, gat_s1};
    end
  end

  assign clk_rise = clk_s2 && !clk_s3;
  assign gate_ok = !ctrl[CTRL_GATE_EN] || (gat_s2 == ctrl[CTRL_GATE_POS]); // RULE_16
  assign bit_stb = clk_rise && gate_ok && ctrl[CTRL_ENABLE];
  assign bit_d = dat_s2;
  assign pred = ref_q[PN_ORDER-1] ^ ref_q[PN_TAP-1];
  assign err_bit = bit_d ^ pred;
  assign run_same = bit_d == last_bit;
  assign counting = state == S_MEAS && bit_stb && !meas_go;
  assign relock_hit = ctrl[CTRL_RELOCK] && counting && win_cnt == RELOCK_WIN - 16'h0001 &&
                      win_err > limit; // RULE_18
  assign sync_need = SYNC_RUN + (ctrl[CTRL_DELAY_EN] ? delay : 32'h0000_0000); // RULE_17

  //////////////////////////////////////////////////////////////////////////////
  // Reference generator: loads received bits until locked, then free-runs on
  // every qualified bit whatever the sequencer state, so repeats stay aligned.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_q <= '0;
    end else if (bit_stb) begin
      ref_q <= {ref_q[PN_ORDER-2:0], locked ? pred : bit_d}; // RULE_02
    end
  end

  // Loopback source: advances on every rising bit clock edge, ungated.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aux_q <= '1;
      aux_sequence_out <= 1'b0;
    end else begin
      if (clk_rise) begin
        aux_q <= {aux_q[PN_ORDER-2:0], aux_q[PN_ORDER-1] ^ aux_q[PN_TAP-1]};
      end
      aux_sequence_out <= ctrl[CTRL_AUX_EN] && aux_q[PN_ORDER-1]; // RULE_11
    end
  end

  // Bit clock watchdog. Missed edges knock the free-running reference out of
  // step, which then shows up as errors rather than being hidden.
  always_ff @(posedge aclk) begin
    if (!aresetn || clk_rise) begin
      idle_cnt <= 16'h0000;
      no_clock <= 1'b0; // RULE_14
    end else if (idle_cnt == NO_CLK_CYC - 16'h0001) begin
      no_clock <= 1'b1; // RULE_14
    end else begin
      idle_cnt <= idle_cnt + 16'h0001;
    end
  end

  // Run-length tracking for the no-data detector and pattern ignore.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      same_run <= 16'h0000;
      last_bit <= 1'b0;
      no_data <= 1'b0;
    end else if (bit_stb) begin
      last_bit <= bit_d;
      if (!run_same) begin
        same_run <= 16'h0001;
        no_data <= 1'b0; // RULE_13
      end else begin
        if (same_run != 16'hffff) begin
          same_run <= same_run + 16'h0001;
        end
        if (same_run >= NO_DATA_RUN - 16'h0001) begin
          no_data <= 1'b1; // RULE_12
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Errors in an ignored-value run stay pending until the run is long or ends.
  always_comb begin
    next_err = err_cnt;
    next_pend = pend;
    next_hit = ign_hit;
    if (!run_same) begin
      if (!ign_hit) begin
        next_err = err_cnt + pend;
      end
      next_pend = 32'h0000_0000;
      next_hit = 1'b0;
    end
    if (ctrl[CTRL_IGN_EN] && bit_d == ctrl[CTRL_IGN_ONES]) begin
      if (run_same && same_run >= IGNORE_RUN - 16'h0001) begin
        next_hit = 1'b1; // RULE_19
      end
      if (!next_hit) begin
        next_pend = next_pend + {31'h0, err_bit};
      end
    end else begin
      next_err = next_err + {31'h0, err_bit}; // RULE_12
    end
    if (no_data && !run_same) begin
      next_err = 32'h0000_0000; // RULE_13
      next_pend = 32'h0000_0000;
      next_hit = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !ctrl[CTRL_ENABLE] || meas_go) begin
      tot_cnt <= 32'h0000_0000; // RULE_15
      err_cnt <= 32'h0000_0000;
      pend <= 32'h0000_0000;
      ign_hit <= 1'b0;
      win_cnt <= 16'h0000;
      win_err <= 32'h0000_0000;
    end else if (counting) begin
      tot_cnt <= tot_cnt + 32'h0000_0001; // RULE_19
      err_cnt <= next_err;
      pend <= next_pend;
      ign_hit <= next_hit;
      if (win_cnt == RELOCK_WIN - 16'h0001) begin
        win_cnt <= 16'h0000;
        win_err <= 32'h0000_0000;
      end else begin
        win_cnt <= win_cnt + 16'h0001;
        win_err <= win_err + {31'h0, err_bit};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Ratio divider: Q0.16 of errored over total bits, one quotient bit a cycle.
  assign div_done = div_i == 5'(RATIO_FRAC + 1);
  assign div_shift = {div_rem[31:0], 1'b0};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_i <= 5'h00;
      div_rem <= 33'h0_0000_0000;
      div_q <= 16'h0000;
      ratio <= 16'h0000;
    end else if (state != S_DIV) begin
      div_i <= 5'h00;
    end else if (div_i == 5'h00) begin
      div_rem <= {1'b0, err_cnt};
      div_q <= (err_cnt >= tot_cnt) ? 16'hffff : 16'h0000;
      div_i <= (err_cnt >= tot_cnt) ? 5'(RATIO_FRAC + 1) : 5'h01;
    end else if (!div_done) begin
      div_rem <= (div_shift >= {1'b0, tot_cnt}) ? div_shift - {1'b0, tot_cnt} : div_shift;
      div_q <= {div_q[14:0], div_shift >= {1'b0, tot_cnt}}; // RULE_20
      div_i <= div_i + 5'h01;
    end else begin
      ratio <= div_q; // RULE_20
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Measurement sequencer. Clearing the enable drops everything back to idle
  // so the next start reacquires from scratch.
  always_ff @(posedge aclk) begin
    if (!aresetn || !ctrl[CTRL_ENABLE]) begin
      state <= S_IDLE; // RULE_15
      measurement_active_out <= 1'b0;
      result_pulse_out <= 1'b0;
      locked <= 1'b0;
      sync_lost <= 1'b0;
      meas_go <= 1'b0;
      tmr <= 32'h0000_0000;
      match_run <= 32'h0000_0000;
      done_cnt <= 32'h0000_0000;
    end else begin
      meas_go <= 1'b0;
      if (no_clock && locked && state != S_IDLE) begin
        sync_lost <= 1'b1; // RULE_14
      end
      case (state)
        S_IDLE: begin
          if (trig_wr || ctrl[CTRL_CONT]) begin
            measurement_active_out <= 1'b1; // RULE_05
            locked <= 1'b0; // RULE_04
            sync_lost <= 1'b0;
            done_cnt <= 32'h0000_0000;
            match_run <= 32'h0000_0000;
            tmr <= 32'h0000_0000;
            state <= (ctrl[CTRL_DELAY_EN] && delay != 32'h0000_0000) ? S_DELAY : S_ACQ;
          end
        end
        S_DELAY: begin
          if (bit_stb) begin
            tmr <= tmr + 32'h0000_0001;
            if (tmr == delay - 32'h0000_0001) begin
              state <= S_ACQ; // RULE_17
            end
          end
        end
        S_ACQ: begin
          if (bit_stb) begin
            if (bit_d == pred) begin
              match_run <= match_run + 32'h0000_0001;
              if (match_run + 32'h0000_0001 >= sync_need) begin
                locked <= 1'b1;
                meas_go <= 1'b1;
                state <= S_MEAS;
              end
            end else begin
              match_run <= 32'h0000_0000;
            end
          end
        end
        S_MEAS: begin
          if (relock_hit) begin
            locked <= 1'b0; // RULE_18
            match_run <= 32'h0000_0000;
            state <= S_ACQ;
          end else if (counting && tot_cnt == block_len - 32'h0000_0001) begin
            state <= S_DIV; // RULE_03
          end
        end
        S_DIV: begin
          if (div_done) begin
            result_pulse_out <= 1'b1;
            tmr <= 32'h0000_0000;
            state <= S_PULSE;
          end
        end
        S_PULSE: begin
          tmr <= tmr + 32'h0000_0001;
          if (tmr == {16'h0000, RESULT_CYC} - 32'h0000_0001) begin
            result_pulse_out <= 1'b0; // RULE_09
            tmr <= 32'h0000_0000;
            state <= S_TAIL;
          end
        end
        S_TAIL: begin
          tmr <= tmr + 32'h0000_0001;
          if (tmr == {16'h0000, TAIL_CYC} - 32'h0000_0001) begin
            measurement_active_out <= 1'b0; // RULE_07
            done_cnt <= done_cnt + 32'h0000_0001;
            if (cycles == 32'h0000_0000 || done_cnt + 32'h0000_0001 < cycles) begin
              state <= S_GAP;
            end else begin
              state <= S_IDLE;
            end
          end
        end
        S_GAP: begin
          // Next cycle of a repeat: no reacquisition, reference keeps running.
          measurement_active_out <= 1'b1; // RULE_01
          meas_go <= 1'b1;
          state <= S_MEAS;
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

endmodule

// [bms_pkg.sv]
package bms_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TRIG = 8'h04;
  localparam logic [7:0] ADDR_BLOCK = 8'h08;
  localparam logic [7:0] ADDR_CYCLES = 8'h0c;
  localparam logic [7:0] ADDR_DELAY = 8'h10;
  localparam logic [7:0] ADDR_LIMIT = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_TOTAL = 8'h1c;
  localparam logic [7:0] ADDR_ERRORS = 8'h20;
  localparam logic [7:0] ADDR_RATIO = 8'h24;
  localparam logic [7:0] ADDR_DONE = 8'h28;

  //////////////////////////////////////////////////////////////////////////////
  // Control and status field positions.
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_GATE_EN = 1;
  localparam int CTRL_GATE_POS = 2;
  localparam int CTRL_DELAY_EN = 3;
  localparam int CTRL_RELOCK = 4;
  localparam int CTRL_IGN_EN = 5;
  localparam int CTRL_IGN_ONES = 6;
  localparam int CTRL_CONT = 7;
  localparam int CTRL_AUX_EN = 8;
  localparam int STAT_ACTIVE = 0;
  localparam int STAT_LOCKED = 1;
  localparam int STAT_NO_DATA = 2;
  localparam int STAT_NO_CLOCK = 3;
  localparam int STAT_SYNC_LOST = 4;
  localparam int STAT_RESULT = 5;

  //////////////////////////////////////////////////////////////////////////////
  // Values after reset.
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] BLOCK_RST = 32'h0000_2710;
  localparam logic [31:0] CYCLES_RST = 32'h0000_0001;
  localparam logic [31:0] DELAY_RST = 32'h0000_0000;
  localparam logic [31:0] LIMIT_RST = 32'h0000_0080;

  //////////////////////////////////////////////////////////////////////////////
  // Sequence and detector constants.
  localparam int PN_ORDER = 9;
  localparam int PN_TAP = 5;
  localparam logic [31:0] SYNC_RUN = 32'h0000_0012;
  localparam logic [15:0] IGNORE_RUN = 16'h00a0;
  localparam logic [15:0] NO_DATA_RUN = 16'h0200;
  localparam logic [15:0] RELOCK_WIN = 16'h0400;
  localparam int RATIO_FRAC = 16;

  //////////////////////////////////////////////////////////////////////////////
  // Timing, converted from nanoseconds at the aclk period.
  localparam int CLK_PERIOD_PS = 8000;
  localparam int NO_CLK_NS = 10000;
  localparam int RESULT_NS = 80;
  localparam int TAIL_NS = 40;
  localparam logic [15:0] NO_CLK_CYC = 16'(NO_CLK_NS * 1000 / CLK_PERIOD_PS);
  localparam logic [15:0] RESULT_CYC = 16'((RESULT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  localparam logic [15:0] TAIL_CYC = 16'((TAIL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    S_IDLE, S_DELAY, S_ACQ, S_MEAS, S_DIV, S_PULSE, S_TAIL, S_GAP
  } bms_state_t;

endpackage

// [bms_top_asserts.sv]
`timescale 1ns/1ps
////////////////////
// Watches the result strobes and bus answers at the block's ports.
module bms_top_asserts (
  input wire logic aclk, // Clock.
  input wire logic aresetn, // Reset.
  input wire logic s_axi_awvalid, // Valid.
  input wire logic s_axi_awready, // Ready.
  input wire logic s_axi_wvalid, // Valid.
  input wire logic s_axi_wready, // Ready.
  input wire logic s_axi_bvalid, // Valid.
  input wire logic s_axi_bready, // Ready.
  input wire logic s_axi_arvalid, // Valid.
  input wire logic s_axi_arready, // Ready.
  input wire logic s_axi_rvalid, // Valid.
  input wire logic s_axi_rready, // Ready.
  input wire logic measurement_active_out, // Running.
  input wire logic result_pulse_out // Strobe.
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [3:0] pw;
  // Counts the strobe length, since a long repetition would unroll too far.
  always_ff @(posedge aclk) pw <= (aresetn && result_pulse_out) ? pw + 4'h1 : 4'h0;
  // The strobe lasts ten cycles and stays inside the active window.
  a_pulse_len: assert property ($fell(result_pulse_out) |-> pw == 4'ha)
    else $error("pulse width");
  a_pulse_inside: assert property (result_pulse_out |->
    measurement_active_out) else $error("pulse outside run");
  a_tail_end: assert property ($fell(result_pulse_out) |->
    measurement_active_out ##[1:8] !measurement_active_out) else $error("tail");
  a_fall_clean: assert property ($fell(measurement_active_out) |->
    !result_pulse_out && !$past(result_pulse_out)) else $error("late pulse");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("no write answer");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("no read answer");
  a_read_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  a_write_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
endmodule
bind bms_top bms_top_asserts bms_top_asserts_inst (.*);

// [bms_uut_model.sv]
`timescale 1ns/1ps
////////////////////
// Far-side source of PN9 bits; data moves on the falling edge for setup margin.
module bms_uut_model (
  input wire logic run, // Frame on.
  input wire logic stuck, // Data lost.
  input wire logic [7:0] flips, // Bits to corrupt.
  output logic bit_clock_in, // Bit clock.
  output logic bit_data_in // Data.
);
  logic [8:0] sr = 9'h1ff;
  logic f;
  int n = 0;
  int done = 0;
  // Clock stands still between frames; the idle data line keeps changing.
  initial begin
    bit_clock_in = 1'b0;
    bit_data_in = 1'b0;
    forever begin
      #62.5;
      if (!run) begin
        bit_data_in = ~bit_data_in;
      end else begin
        bit_clock_in = ~bit_clock_in;
        if (!bit_clock_in) begin
          sr = {sr[7:0], sr[8] ^ sr[4]};
          n++;
          f = done < flips && n % 20 == 0; // Spaced so each flip is one error.
          done += f;
          bit_data_in = stuck ? 1'b0 : sr[0] ^ f;
        end
      end
    end
  end
endmodule

// [bms_top_tb.sv]
`timescale 1ns/1ps
module bms_top_tb import bms_pkg::*;;
  localparam logic [31:0] BLK = 32'h0000_012c; // Short block keeps the run brief.
  logic aclk = 1'b0, aresetn = 1'b0, run = 1'b0, stuck = 1'b0, pp = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic clock_qualifier_in = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, bit_clock_in, bit_data_in;
  logic measurement_active_out, result_pulse_out;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, flips = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [1:0] s_axi_rresp, r;
  int fails = 0, n_checks = 0, cyc = 0, pulses = 0, seed = 25713, k, np;
  bms_top bms_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp(),
    .s_axi_bvalid, .s_axi_bready(1'b1), .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'b1), .bit_clock_in,
    .bit_data_in, .clock_qualifier_in, .measurement_active_out, .result_pulse_out,
    .aux_sequence_out());
  bms_uut_model bms_uut_model_inst (.run, .stuck, .flips, .bit_clock_in, .bit_data_in);
  initial forever #4 aclk = ~aclk;
  // Strobe count, random gate noise (gating off) and hang guard.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    pp <= result_pulse_out;
    clock_qualifier_in <= 1'($random(seed));
    if (result_pulse_out && !pp) pulses <= pulses + 1;
    if (cyc == 60000) begin
      fails = fails + 1;
      end_of_test();
    end
  end
  ////////////////////
  task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: data %h not %h", $time, got, exp);
    end
  endtask
  task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: resp %h not %h", $time, got, exp);
    end
  endtask
  // Address and data go out together; each is released once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] v);
    rd(a);
    cmp_data(d, v);
    cmp_resp(r, RESP_OKAY);
  endtask
  task automatic wait_stat(input int b, input logic v);
    do rd(ADDR_STATUS); while (d[b] !== v);
  endtask
  task automatic end_of_test;
    if (fails == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  ////////////////////
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rchk(ADDR_BLOCK, 32'h0000_2710);
    rchk(ADDR_CYCLES, 32'h0000_0001);
    rd(8'h30);
    cmp_resp(r, RESP_SLVERR);
    // Random corrupted bits; a second trigger must be ignored.
    k = 1 + ($unsigned($random(seed)) % 8);
    run <= 1'b1;
    wr(ADDR_CTRL, 32'h0000_0101);
    wr(ADDR_BLOCK, BLK);
    wr(ADDR_TRIG, 32'h0000_0001);
    wait_stat(STAT_LOCKED, 1'b1);
    repeat (60) @(posedge aclk);
    flips <= flips + 8'(k);
    wr(ADDR_TRIG, 32'h0000_0001);
    wait_stat(STAT_ACTIVE, 1'b0);
    repeat (40) @(posedge aclk);
    cmp_data(32'(pulses), 32'h1);
    rchk(ADDR_TOTAL, BLK);
    rchk(ADDR_ERRORS, 32'(k));
    rchk(ADDR_RATIO, 32'(k * 65536 / int'(BLK)));
    // Two cycles on one sync: clean stream, zero errors in the last.
    wr(ADDR_CYCLES, 32'h0000_0002);
    wr(ADDR_TRIG, 32'h0000_0001);
    while (pulses < 3 || measurement_active_out) @(posedge aclk);
    rchk(ADDR_ERRORS, 32'h0);
    // Endless cycles: lose the data, then the clock.
    wr(ADDR_CYCLES, 32'h0);
    wr(ADDR_TRIG, 32'h0000_0001);
    wait_stat(STAT_LOCKED, 1'b1);
    stuck <= 1'b1;
    wait_stat(STAT_NO_DATA, 1'b1);
    stuck <= 1'b0;
    wait_stat(STAT_NO_DATA, 1'b0);
    rchk(ADDR_ERRORS, 32'h0);
    run <= 1'b0;
    wait_stat(STAT_NO_CLOCK, 1'b1);
    run <= 1'b1;
    wait_stat(STAT_NO_CLOCK, 1'b0);
    repeat (400) @(posedge aclk);
    rd(ADDR_STATUS);
    cmp_data(32'(d[STAT_SYNC_LOST]), 32'h1);
    // Off and on again gives a fresh, clean measurement.
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_CYCLES, 32'h0000_0001);
    wr(ADDR_CTRL, 32'h0000_0101);
    np = pulses + 1;
    wr(ADDR_TRIG, 32'h0000_0001);
    while (pulses < np || measurement_active_out) @(posedge aclk);
    rchk(ADDR_ERRORS, 32'h0);
    rchk(ADDR_RATIO, 32'h0);
    end_of_test();
  end
endmodule
